// File: common/mftd_defs.svh
// register offsets, field positions, reset values and timing counts of the totalizer/dio core
`ifndef MFTD_DEFS_SVH
`define MFTD_DEFS_SVH

`define MFTD_ADDR_W 6
`define MFTD_OFF_CTRL 6'h00
`define MFTD_OFF_COUNT 6'h04
`define MFTD_OFF_SNAP_COUNT 6'h08
`define MFTD_OFF_PORT_IN 6'h0C
`define MFTD_OFF_SNAP_PORT 6'h10
`define MFTD_OFF_PORT_OUT 6'h14
`define MFTD_OFF_ALM_CFG 6'h18
`define MFTD_OFF_DAC0 6'h1C
`define MFTD_OFF_DAC1 6'h20
`define MFTD_OFF_IRQ_STAT 6'h24
`define MFTD_OFF_IRQ_EN 6'h28
`define MFTD_OFF_IRQ_CLR 6'h2C

// ctrl fields
`define MFTD_CTRL_FALL 0
`define MFTD_CTRL_JOIN 1
`define MFTD_CTRL_CLEAR 2
`define MFTD_CTRL_SCAN 3
`define MFTD_CTRL_MODE0 4
`define MFTD_CTRL_MODE1 5
`define MFTD_CTRL_AEN0 6
`define MFTD_CTRL_AEN1 7
`define MFTD_CTRL_OE0 8
`define MFTD_CTRL_OE1 9
`define MFTD_CTRL_W 10
`define MFTD_CTRL_RST 10'h000

// irq status fields
`define MFTD_IRQ_ALM0 0
`define MFTD_IRQ_ALM1 1
`define MFTD_IRQ_WRAP 2
`define MFTD_IRQ_SCAN 3
`define MFTD_IRQ_W 4

`define MFTD_PORT_OUT_RST 16'hFFFF
`define MFTD_ALM_CFG_RST 32'h0000_0000
`define MFTD_DAC_RST 16'h0000

// fastest documented pulse rate and the clock period it is sampled with
`define MFTD_CLK_PERIOD_NS 4
`define MFTD_PULSE_PERIOD_NS 10000
`define MFTD_PULSE_CYCLES (`MFTD_PULSE_PERIOD_NS / `MFTD_CLK_PERIOD_NS)
`define MFTD_SYNC_STAGES 2

`endif

// File: common/mftd_pkg.sv
// types shared by the totalizer/dio core
package mftd_pkg;

	typedef enum logic [0:0] {
		MFTD_ALM_MATCH = 1'b0,
		MFTD_ALM_CHANGE = 1'b1
	} mftd_alm_mode_t;

	typedef enum logic [0:0] {
		MFTD_EDGE_RISE = 1'b0,
		MFTD_EDGE_FALL = 1'b1
	} mftd_edge_t;

endpackage : mftd_pkg

// File: design/mftd_sync.sv
// two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/100ps
module mftd_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : mftd_sync

// File: design/mftd_top.sv
// totalizer, two 8-bit digital ports with alarms, and dac setpoints behind an avalon-mm slave
`timescale 1ns/100ps
`include "mftd_defs.svh"

// Summary of operation
// - A 26-bit accumulator counts pulse edges, fast enough for 100 kHz input without losing any.
// - A control bit chooses whether the rising or the falling pulse edge is counted.
// - From its maximum of 67,108,863 the accumulator wraps to zero on the next counted edge.
// - The active-high gate permits counting when high and blocks it when low.
// - The active-low gate permits counting when low and blocks it when high.
// - An edge is counted only while both gates permit it, otherwise it is dropped.
// - An unconnected gate is pulled to its permitting level, so no gate wiring means counting always.
// - The count can be read live or taken as a snapshot by a scan step.
// - Both 8-bit ports can be read live or captured by a scan step.
// - A pattern match or a change on a port raises an alarm whether or not it is scanned.
// - An open pulled-up input reads 1 and a grounded input reads 0.
// - Each port drives a programmed pattern, and both ports can act as one 16-bit word.
// - Each of two dac channels holds a 16-bit setpoint in 1 mV steps over -12 V to +12 V.
module mftd_top #(
	parameter int CNT_W = 26,
	parameter int PORT_W = 8,
	parameter int DAC_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [`MFTD_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// totalizer pins
	input wire logic pulse_in,
	input wire logic gate_hi_in,
	input wire logic gate_lo_n_in,
	// digital ports: port 0 in bits 7:0, port 1 in bits 15:8
	input wire logic [2*PORT_W-1:0] dio_i,
	output logic [2*PORT_W-1:0] dio_o,
	output logic [2*PORT_W-1:0] dio_oe,
	// dac setpoints
	output logic [DAC_W-1:0] dac0_code,
	output logic [DAC_W-1:0] dac1_code,
	output logic irq
);

	localparam int PW2 = 2 * PORT_W;
	localparam int SW = PW2 + 3;
	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

	// masked pattern compare, used for both ports
	function automatic logic pat_match(input logic [PORT_W-1:0] val, input logic [PORT_W-1:0] pat,
		input logic [PORT_W-1:0] msk);
		pat_match = ((val ^ pat) & msk) == '0;
	endfunction : pat_match

	// ---------------- input synchronisation ----------------
	logic [SW-1:0] sync_q;
	mftd_sync #(.W(SW)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({gate_lo_n_in, gate_hi_in, pulse_in, dio_i}),
		.q(sync_q)
	);

	wire [PW2-1:0] port_s = sync_q[PW2-1:0];
	wire pulse_s = sync_q[PW2];
	wire gate_hi_s = sync_q[PW2+1];
	wire gate_lo_n_s = sync_q[PW2+2];

	// ---------------- registers ----------------
	logic [`MFTD_CTRL_W-1:0] ctrl_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] snap_cnt_q;
	logic [PW2-1:0] snap_port_q;
	logic [PW2-1:0] out_q;
	logic [31:0] alm_cfg_q;
	logic [DAC_W-1:0] dac0_q;
	logic [DAC_W-1:0] dac1_q;
	logic [`MFTD_IRQ_W-1:0] stat_q;
	logic [`MFTD_IRQ_W-1:0] irq_en_q;
	logic [`MFTD_IRQ_W-1:0] stat_d;
	logic [31:0] rdata_q;
	logic wait_q;
	logic irq_q;
	logic pulse_prev_q;
	logic [PW2-1:0] port_prev_q;
	logic [1:0] match_prev_q;
	logic clear_q;
	logic scan_q;

	// ---------------- bus decode ----------------
	// one wait cycle: waitrequest drops for the cycle after a request is seen
	wire req = read | write;
	wire wr_en = write & ~wait_q;
	wire [`MFTD_ADDR_W-1:0] word_addr = {address[`MFTD_ADDR_W-1:2], 2'b00};
	wire sel_ctrl = word_addr == `MFTD_OFF_CTRL;
	wire sel_cnt = word_addr == `MFTD_OFF_COUNT;
	wire sel_snap_cnt = word_addr == `MFTD_OFF_SNAP_COUNT;
	wire sel_port_in = word_addr == `MFTD_OFF_PORT_IN;
	wire sel_snap_port = word_addr == `MFTD_OFF_SNAP_PORT;
	wire sel_port_out = word_addr == `MFTD_OFF_PORT_OUT;
	wire sel_alm = word_addr == `MFTD_OFF_ALM_CFG;
	wire sel_dac0 = word_addr == `MFTD_OFF_DAC0;
	wire sel_dac1 = word_addr == `MFTD_OFF_DAC1;
	wire sel_stat = word_addr == `MFTD_OFF_IRQ_STAT;
	wire sel_en = word_addr == `MFTD_OFF_IRQ_EN;
	wire sel_clr = word_addr == `MFTD_OFF_IRQ_CLR;

	wire [31:0] be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
	wire [31:0] wmask = wr_en ? be_mask : 32'h0000_0000;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	wire [31:0] ctrl_ext = {{(32 - `MFTD_CTRL_W){1'b0}}, ctrl_q};
	wire [31:0] ctrl_wr = merge(ctrl_ext, writedata, sel_ctrl ? wmask : 32'h0000_0000);
	wire clear_wr = wr_en & sel_ctrl & byteenable[0] & writedata[`MFTD_CTRL_CLEAR];
	wire scan_wr = wr_en & sel_ctrl & byteenable[0] & writedata[`MFTD_CTRL_SCAN];

	// joined mode writes both ports as one word when any low lane is enabled
	wire join16 = ctrl_q[`MFTD_CTRL_JOIN];
	wire [1:0] out_lane = join16 ? {2{|byteenable[1:0]}} : byteenable[1:0];
	wire [PW2-1:0] out_m = (wr_en & sel_port_out) ? {{PORT_W{out_lane[1]}}, {PORT_W{out_lane[0]}}} : '0;
	wire [PW2-1:0] out_d = (out_q & ~out_m) | (writedata[PW2-1:0] & out_m);

	wire [31:0] alm_d = merge(alm_cfg_q, writedata, sel_alm ? wmask : 32'h0000_0000);
	wire [31:0] dac0_ext = {{(32 - DAC_W){1'b0}}, dac0_q};
	wire [31:0] dac1_ext = {{(32 - DAC_W){1'b0}}, dac1_q};
	wire [31:0] dac0_d = merge(dac0_ext, writedata, sel_dac0 ? wmask : 32'h0000_0000);
	wire [31:0] dac1_d = merge(dac1_ext, writedata, sel_dac1 ? wmask : 32'h0000_0000);
	wire [`MFTD_IRQ_W-1:0] en_d = (wr_en & sel_en & byteenable[0]) ? writedata[`MFTD_IRQ_W-1:0] : irq_en_q;
	wire [`MFTD_IRQ_W-1:0] clr_m = (wr_en & sel_clr & byteenable[0]) ? writedata[`MFTD_IRQ_W-1:0] : '0;

	// ---------------- totalizer ----------------
	wire fall_sel = ctrl_q[`MFTD_CTRL_FALL];
	wire edge_rise = pulse_s & ~pulse_prev_q;
	wire edge_fall = ~pulse_s & pulse_prev_q;
	wire edge_hit = (fall_sel == mftd_pkg::MFTD_EDGE_FALL) ? edge_fall : edge_rise;
	// pins are pulled to the permitting level when open
	wire gate_ok = gate_hi_s & ~gate_lo_n_s;
	wire cnt_inc = edge_hit & gate_ok;
	wire cnt_wrap = cnt_inc & (cnt_q == CNT_MAX);
	wire [CNT_W-1:0] cnt_next = cnt_wrap ? '0 : cnt_q + CNT_W'(1);
	// a clear keeps an edge that lands in the same cycle
	wire [CNT_W-1:0] cnt_d = clear_q ? (cnt_inc ? CNT_W'(1) : '0) : (cnt_inc ? cnt_next : cnt_q);

	// scan step: capture the count and both ports in the same cycle
	wire [CNT_W-1:0] snap_cnt_d = scan_q ? cnt_q : snap_cnt_q;
	wire [PW2-1:0] snap_port_d = scan_q ? port_s : snap_port_q;

	// ---------------- alarms ----------------
	wire [PORT_W-1:0] pat0 = alm_cfg_q[PORT_W-1:0];
	wire [PORT_W-1:0] msk0 = alm_cfg_q[2*PORT_W-1:PORT_W];
	wire [PORT_W-1:0] pat1 = alm_cfg_q[3*PORT_W-1:2*PORT_W];
	wire [PORT_W-1:0] msk1 = alm_cfg_q[4*PORT_W-1:3*PORT_W];
	wire [1:0] match_now = {pat_match(port_s[PW2-1:PORT_W], pat1, msk1), pat_match(port_s[PORT_W-1:0], pat0, msk0)};
	wire [1:0] match_new = match_now & ~match_prev_q;
	wire chg0 = |((port_s[PORT_W-1:0] ^ port_prev_q[PORT_W-1:0]) & msk0);
	wire chg1 = |((port_s[PW2-1:PORT_W] ^ port_prev_q[PW2-1:PORT_W]) & msk1);
	wire mode0 = ctrl_q[`MFTD_CTRL_MODE0];
	wire mode1 = ctrl_q[`MFTD_CTRL_MODE1];
	wire ev_alm0 = ctrl_q[`MFTD_CTRL_AEN0] & ((mode0 == mftd_pkg::MFTD_ALM_CHANGE) ? chg0 : match_new[0]);
	wire ev_alm1 = ctrl_q[`MFTD_CTRL_AEN1] & ((mode1 == mftd_pkg::MFTD_ALM_CHANGE) ? chg1 : match_new[1]);

	// ---------------- interrupt status ----------------
	wire [`MFTD_IRQ_W-1:0] events = {scan_q, cnt_wrap, ev_alm1, ev_alm0};
	always_comb begin
		stat_d = (stat_q & ~clr_m) | events;
	end

	// ---------------- read mux ----------------
	wire [31:0] rd_mux =
		sel_ctrl ? ctrl_ext :
		sel_cnt ? {{(32 - CNT_W){1'b0}}, cnt_q} :
		sel_snap_cnt ? {{(32 - CNT_W){1'b0}}, snap_cnt_q} :
		sel_port_in ? {{(32 - PW2){1'b0}}, port_s} :
		sel_snap_port ? {{(32 - PW2){1'b0}}, snap_port_q} :
		sel_port_out ? {{(32 - PW2){1'b0}}, out_q} :
		sel_alm ? alm_cfg_q :
		sel_dac0 ? dac0_ext :
		sel_dac1 ? dac1_ext :
		sel_stat ? {{(32 - `MFTD_IRQ_W){1'b0}}, stat_q} :
		sel_en ? {{(32 - `MFTD_IRQ_W){1'b0}}, irq_en_q} :
		32'h0000_0000;

	// ---------------- flip-flops ----------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~(req & wait_q);
			if (req & wait_q) begin
				rdata_q <= read ? rd_mux : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `MFTD_CTRL_RST;
			clear_q <= 1'b0;
			scan_q <= 1'b0;
		end else begin
			// clear and scan bits are self-clearing strobes
			ctrl_q <= ctrl_wr[`MFTD_CTRL_W-1:0] & ~(`MFTD_CTRL_W'(1) << `MFTD_CTRL_CLEAR)
				& ~(`MFTD_CTRL_W'(1) << `MFTD_CTRL_SCAN);
			clear_q <= clear_wr;
			scan_q <= scan_wr;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			pulse_prev_q <= 1'b0;
			snap_cnt_q <= '0;
			snap_port_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			pulse_prev_q <= pulse_s;
			snap_cnt_q <= snap_cnt_d;
			snap_port_q <= snap_port_d;
		end
	end

	// previous-value flops are seeded from the live port after reset to avoid a false change
	logic armed_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
			port_prev_q <= '0;
			match_prev_q <= 2'b11;
		end else begin
			armed_q <= 1'b1;
			port_prev_q <= port_s;
			match_prev_q <= armed_q ? match_now : 2'b11;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_q <= `MFTD_PORT_OUT_RST;
			alm_cfg_q <= `MFTD_ALM_CFG_RST;
			dac0_q <= `MFTD_DAC_RST;
			dac1_q <= `MFTD_DAC_RST;
		end else begin
			out_q <= out_d;
			alm_cfg_q <= alm_d;
			dac0_q <= dac0_d[DAC_W-1:0];
			dac1_q <= dac1_d[DAC_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stat_q <= '0;
			irq_en_q <= '0;
			irq_q <= 1'b0;
		end else begin
			stat_q <= armed_q ? stat_d : '0;
			irq_en_q <= en_d;
			irq_q <= |((armed_q ? stat_d : '0) & en_d);
		end
	end

	// pin drivers: output enable follows the per-port direction bit
	logic [PW2-1:0] dio_o_q;
	logic [PW2-1:0] dio_oe_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dio_o_q <= `MFTD_PORT_OUT_RST;
			dio_oe_q <= '0;
		end else begin
			dio_o_q <= out_d;
			dio_oe_q <= {{PORT_W{ctrl_wr[`MFTD_CTRL_OE1]}}, {PORT_W{ctrl_wr[`MFTD_CTRL_OE0]}}};
		end
	end

	assign readdata = rdata_q;
	assign waitrequest = wait_q;
	assign dio_o = dio_o_q;
	assign dio_oe = dio_oe_q;
	assign dac0_code = dac0_q;
	assign dac1_code = dac1_q;
	assign irq = irq_q;

endmodule : mftd_top

// File: test/mftd_top_monitor.sv
// port-level assertions for the totalizer/dio core
`timescale 1ns/100ps
`include "mftd_defs.svh"
module mftd_top_monitor #(
	parameter int CNT_W = 26,
	parameter int PORT_W = 8,
	parameter int DAC_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`MFTD_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic [2*PORT_W-1:0] dio_o,
	input wire logic [2*PORT_W-1:0] dio_oe,
	input wire logic [DAC_W-1:0] dac0_code,
	input wire logic irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	wire logic wr_ack = write && !waitrequest;
	wire logic rd_ack = read && !waitrequest;

	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("no single-cycle answer");
	a_wait_idle: assert property (!(read || write) && waitrequest |=> waitrequest)
		else $error("answer without request");
	a_dac_value: assert property (wr_ack && address == `MFTD_OFF_DAC0 && byteenable == 4'hF
		|=> dac0_code == $past(writedata[DAC_W-1:0]))
		else $error("dac code not taken");
	a_dac_hold: assert property ($changed(dac0_code) |-> $past(wr_ack && address == `MFTD_OFF_DAC0))
		else $error("dac code moved alone");
	a_out_hold: assert property ($changed(dio_o) |-> $past(wr_ack && address == `MFTD_OFF_PORT_OUT))
		else $error("port output moved alone");
	a_oe_hold: assert property ($changed(dio_oe) |-> $past(wr_ack && address == `MFTD_OFF_CTRL))
		else $error("drive enable moved alone");
	a_oe_per_port: assert property (dio_oe[PORT_W-1:0] inside {'0, '1} && dio_oe[2*PORT_W-1:PORT_W] inside {'0, '1})
		else $error("drive enable split in a port");
	a_rd_unmapped: assert property (rd_ack && address[5:4] == 2'b11 |-> readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_rd_clr_zero: assert property (rd_ack && address == `MFTD_OFF_IRQ_CLR |-> readdata == 32'h0000_0000)
		else $error("clear register read not zero");

	c_read: cover property (rd_ack);
	c_dac: cover property (wr_ack && address == `MFTD_OFF_DAC0);
	c_irq: cover property ($rose(irq));
	c_drive: cover property ($rose(dio_oe[0]));
endmodule : mftd_top_monitor

// File: test/mftd_far_model.sv
// pulse source, gate wiring and switch contacts at the far side of the core
`timescale 1ns/100ps
module mftd_far_model (
	input wire logic clk,
	input wire logic hi_open,
	input wire logic hi_lvl,
	input wire logic lo_open,
	input wire logic lo_lvl,
	input wire logic [15:0] closed,
	input wire logic [15:0] dio_o,
	input wire logic [15:0] dio_oe,
	output logic pulse_in,
	output logic gate_hi_in,
	output logic gate_lo_n_in,
	output logic [15:0] dio_i
);
	initial pulse_in = 1'b0;
	// an open gate pin floats to its enabling level
	assign gate_hi_in = hi_open ? 1'b1 : hi_lvl;
	assign gate_lo_n_in = lo_open ? 1'b0 : lo_lvl;
	// pins pull up; a closed contact or a bit driven low sinks the pin
	assign dio_i = ~closed & ~(dio_oe & ~dio_o);

	task automatic half(input logic v);
		repeat (4) @(posedge clk);
		pulse_in <= v;
	endtask : half

	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			half(1'b1);
			half(1'b0);
		end
		repeat (6) @(posedge clk);
	endtask : pulses
endmodule : mftd_far_model

// File: test/mftd_top_tb.sv
// self-checking bench for the totalizer/dio core
`timescale 1ns/100ps
`include "mftd_defs.svh"
module mftd_top_tb;
	logic clk = 1'b0;
	logic rst;
	logic [5:0] address;
	logic read;
	logic write;
	logic [3:0] byteenable;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest, pulse_in, gate_hi_in, gate_lo_n_in, irq;
	logic [15:0] dio_i, dio_o, dio_oe, dac0_code, dac1_code;
	logic hi_open;
	logic hi_lvl;
	logic lo_open;
	logic lo_lvl;
	logic [15:0] closed;
	int n_fail = 0;
	int cmp_count = 0;

	always #2 clk = ~clk;

	// short count width so that the wrap is reached quickly: maximum is 15
	mftd_top #(.CNT_W(4)) uut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.pulse_in(pulse_in), .gate_hi_in(gate_hi_in), .gate_lo_n_in(gate_lo_n_in), .dio_i(dio_i),
		.dio_o(dio_o), .dio_oe(dio_oe), .dac0_code(dac0_code), .dac1_code(dac1_code), .irq(irq));
	mftd_far_model far (.clk(clk), .hi_open(hi_open), .hi_lvl(hi_lvl), .lo_open(lo_open), .lo_lvl(lo_lvl),
		.closed(closed), .dio_o(dio_o), .dio_oe(dio_oe), .pulse_in(pulse_in), .gate_hi_in(gate_hi_in),
		.gate_lo_n_in(gate_lo_n_in), .dio_i(dio_i));

	task automatic finish_test;
		if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= 1'b1;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		@(posedge clk);
		address <= a;
		read <= 1'b1;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		read <= 1'b0;
		chk(readdata, exp);
	endtask : rd

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		finish_test();
	end

	initial begin
		rst <= 1'b1;
		address <= 6'h00;
		read <= 1'b0;
		write <= 1'b0;
		byteenable <= 4'h0;
		writedata <= 32'h0000_0000;
		// both gate pins start unconnected
		hi_open <= 1'b1;
		hi_lvl <= 1'b0;
		lo_open <= 1'b1;
		lo_lvl <= 1'b1;
		closed <= 16'h0000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(`MFTD_OFF_PORT_OUT, 32'h0000_FFFF);
		chk(32'(dio_oe), 32'h0000_0000);
		rd(`MFTD_OFF_DAC0, 32'h0000_0000);
		rd(6'h30, 32'h0000_0000);
		far.pulses(5);
		rd(`MFTD_OFF_COUNT, 32'h0000_0005);
		hi_open <= 1'b0;
		far.pulses(2);
		rd(`MFTD_OFF_COUNT, 32'h0000_0005);
		hi_lvl <= 1'b1;
		lo_open <= 1'b0;
		far.pulses(2);
		rd(`MFTD_OFF_COUNT, 32'h0000_0005);
		lo_lvl <= 1'b0;
		far.pulses(1);
		rd(`MFTD_OFF_COUNT, 32'h0000_0006);
		wr(`MFTD_OFF_CTRL, 32'h0000_0001, 4'hF);
		far.half(1'b1);
		repeat (6) @(posedge clk);
		rd(`MFTD_OFF_COUNT, 32'h0000_0006);
		far.half(1'b0);
		repeat (6) @(posedge clk);
		rd(`MFTD_OFF_COUNT, 32'h0000_0007);
		wr(`MFTD_OFF_IRQ_EN, 32'h0000_0004, 4'hF);
		far.pulses(8);
		rd(`MFTD_OFF_COUNT, 32'h0000_000F);
		far.pulses(1);
		rd(`MFTD_OFF_COUNT, 32'h0000_0000);
		rd(`MFTD_OFF_IRQ_STAT, 32'h0000_0004);
		chk(32'(irq), 32'h0000_0001);
		wr(`MFTD_OFF_IRQ_EN, 32'h0000_0000, 4'hF);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0000_0000);
		wr(`MFTD_OFF_IRQ_CLR, 32'h0000_0004, 4'hF);
		rd(`MFTD_OFF_IRQ_STAT, 32'h0000_0000);
		far.pulses(3);
		closed <= 16'h00F0;
		repeat (4) @(posedge clk);
		wr(`MFTD_OFF_CTRL, 32'h0000_0009, 4'hF);
		rd(`MFTD_OFF_SNAP_COUNT, 32'h0000_0003);
		rd(`MFTD_OFF_SNAP_PORT, 32'h0000_FF0F);
		rd(`MFTD_OFF_PORT_IN, 32'h0000_FF0F);
		rd(`MFTD_OFF_IRQ_STAT, 32'h0000_0008);
		wr(`MFTD_OFF_IRQ_CLR, 32'h0000_0008, 4'hF);
		closed <= 16'h0000;
		wr(`MFTD_OFF_ALM_CFG, 32'h0100_FF0F, 4'hF);
		wr(`MFTD_OFF_CTRL, 32'h0000_00E1, 4'hF);
		closed <= 16'h01F0;
		repeat (6) @(posedge clk);
		rd(`MFTD_OFF_IRQ_STAT, 32'h0000_0003);
		wr(`MFTD_OFF_IRQ_CLR, 32'h0000_0003, 4'hF);
		rd(`MFTD_OFF_IRQ_STAT, 32'h0000_0000);
		closed <= 16'h0000;
		// swap the modes: change on port 0, match on port 1
		wr(`MFTD_OFF_CTRL, 32'h0000_00D0, 4'hF);
		wr(`MFTD_OFF_IRQ_CLR, 32'h0000_0003, 4'hF);
		closed <= 16'hFF0F;
		repeat (6) @(posedge clk);
		rd(`MFTD_OFF_IRQ_STAT, 32'h0000_0003);
		rd(`MFTD_OFF_PORT_IN, 32'h0000_00F0);
		closed <= 16'h0000;
		wr(`MFTD_OFF_PORT_OUT, 32'h0000_5AA5, 4'h1);
		rd(`MFTD_OFF_PORT_OUT, 32'h0000_FFA5);
		chk(32'(dio_o), 32'h0000_FFA5);
		wr(`MFTD_OFF_CTRL, 32'h0000_0302, 4'hF);
		// bit 0 low selects the first position of the external selector
		wr(`MFTD_OFF_PORT_OUT, 32'h0000_FFFE, 4'h2);
		@(posedge clk);
		chk(32'(dio_o), 32'h0000_FFFE);
		chk(32'(dio_oe), 32'h0000_FFFF);
		repeat (3) @(posedge clk);
		rd(`MFTD_OFF_PORT_IN, 32'h0000_FFFE);
		wr(`MFTD_OFF_DAC0, 32'h0000_ABCD, 4'hF);
		wr(`MFTD_OFF_DAC1, 32'h0000_1234, 4'hF);
		@(posedge clk);
		chk(32'(dac0_code), 32'h0000_ABCD);
		chk(32'(dac1_code), 32'h0000_1234);
		rd(`MFTD_OFF_DAC1, 32'h0000_1234);
		// a single byte lane leaves the upper half of the code alone
		wr(`MFTD_OFF_DAC0, 32'h0000_1177, 4'h1);
		rd(`MFTD_OFF_DAC0, 32'h0000_AB77);
		rd(`MFTD_OFF_IRQ_CLR, 32'h0000_0000);
		finish_test();
	end
endmodule : mftd_top_tb

bind mftd_top mftd_top_monitor #(.CNT_W(CNT_W), .PORT_W(PORT_W), .DAC_W(DAC_W)) u_mon (.clk(clk), .rst(rst),
	.address(address), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest), .dio_o(dio_o), .dio_oe(dio_oe), .dac0_code(dac0_code),
	.irq(irq));
